// *** core/rsc_ctrl.v ***
// Reset and stop-mode recovery controller with an Avalon-MM slave.
// Assumes one core clock; the pin and monitor inputs are asynchronous.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"

module rsc_ctrl #(
  parameter HOLD_XTAL = `RSC_HOLD_XTAL,
  parameter PORT_W = 8
) (
  input wire core_clk,
  input wire rst,
  input wire [11:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire por_detect,
  input wire supply_low,
  input wire supply_ok,
  input wire watchdog_timeout,
  input wire watchdog_reset_select_option,
  input wire ext_reset_n_in,
  output wire ext_reset_n_out,
  output wire ext_reset_n_oe_n,
  input wire ext_reset_pin_enable,
  input wire xtal_enable_option,
  input wire stop_mode,
  input wire [PORT_W-1:0] port_in,
  input wire [PORT_W-1:0] stop_recovery_enable,
  output wire core_reset,
  output wire periph_reset,
  output wire regs_reset,
  output wire wd_osc_reset,
  output wire port_force_input,
  output wire clk_sel_internal,
  output reg [15:0] vector_fetch_addr,
  output reg vector_fetch_start,
  output reg osc_enable
);

  localparam ST_RUN = 3'd0;
  localparam ST_START = 3'd1;
  localparam ST_COUNT = 3'd2;
  localparam ST_PIN = 3'd3;
  localparam ST_SUPPLY = 3'd4;
  localparam ST_VEC = 3'd5;

  localparam [12:0] START_CYC = `RSC_OSC_START_CYC;
  localparam [12:0] SHORT_CYC = `RSC_HOLD_SHORT;
  localparam [12:0] LONG_CYC = HOLD_XTAL;

  // Held-in-reset level; declared early because the pin filter reads it
  wire in_reset;

  // Two-flop synchronisers for all asynchronous inputs
  reg [5:0] s1_reg;
  reg [5:0] s2_reg;
  reg [PORT_W-1:0] p1_reg;
  reg [PORT_W-1:0] p2_reg;
  reg [PORT_W-1:0] p3_reg;
  always @(posedge core_clk) begin
    s1_reg <= {por_detect, supply_low, supply_ok, watchdog_timeout,
               ~ext_reset_n_in, stop_mode};
    s2_reg <= s1_reg;
    p1_reg <= port_in;
    p2_reg <= p1_reg;
    p3_reg <= p2_reg;
  end
  wire por_s = s2_reg[5];
  wire low_s = s2_reg[4];
  wire ok_s = s2_reg[3];
  wire wdt_s = s2_reg[2];
  wire pin_s = s2_reg[1];
  wire stop_s = s2_reg[0];

  // Pin filter: a held low of four clocks is needed.
  // Only armed while running: during a system reset we sink the pin
  // ourselves, and our own drive must not retrigger the sequence.
  reg [2:0] filt_reg;
  reg pin_req_reg;
  always @(posedge core_clk) begin
    if (rst) begin
      filt_reg <= 3'd0;
      pin_req_reg <= 1'b0;
    end else if (pin_s && ext_reset_pin_enable && !in_reset) begin
      if (filt_reg != 3'd3)
        filt_reg <= filt_reg + 3'd1;
      pin_req_reg <= (filt_reg == 3'd3);
    end else begin
      filt_reg <= 3'd0;
      pin_req_reg <= 1'b0;
    end
  end

  // Port edge detect for stop recovery sources
  wire [PORT_W-1:0] port_edge = (p2_reg ^ p3_reg) & stop_recovery_enable;

  // Debugger control register bit 0 self-clears once the reset starts
  reg dbg_reg;
  wire bus_hit_dbg = avs_write && avs_address == `RSC_OFS_DBGCTL;
  wire dbg_req = dbg_reg;

  wire wdt_rst_req = wdt_s && watchdog_reset_select_option && !stop_s;
  wire power_req = por_s || low_s;
  wire sys_req = power_req || wdt_rst_req || pin_req_reg || dbg_req;
  wire rcv_req = stop_s && (wdt_s || (|port_edge));

  reg [2:0] state_reg;
  reg [12:0] cnt_reg;
  reg sys_kind_reg;
  reg xtal_reg;
  reg [7:0] status_reg;
  reg [7:0] wdctl_reg;
  reg rcv_pulse_reg;

  wire [12:0] hold_len = xtal_reg ? LONG_CYC : SHORT_CYC;

  // Sequencer; any new system request restarts the whole wait.
  // A system request outranks a recovery; recovery is only taken
  // from the running state, so it never cuts a system sequence short.
  // Limitation: a held power or watchdog request keeps the count at zero until it drops.
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_SUPPLY;
      cnt_reg <= 13'd0;
      sys_kind_reg <= 1'b1;
      xtal_reg <= 1'b0;
      rcv_pulse_reg <= 1'b0;
      vector_fetch_addr <= 16'h0000;
      vector_fetch_start <= 1'b0;
    end else begin
      rcv_pulse_reg <= 1'b0;
      vector_fetch_start <= 1'b0;
      if (sys_req) begin
        sys_kind_reg <= 1'b1;
        xtal_reg <= xtal_enable_option;
        cnt_reg <= 13'd0;
        state_reg <= power_req ? ST_SUPPLY : ST_START;
      end else if (rcv_req && state_reg == ST_RUN) begin
        sys_kind_reg <= 1'b0;
        rcv_pulse_reg <= 1'b1;
        xtal_reg <= xtal_enable_option;
        cnt_reg <= 13'd0;
        state_reg <= ST_START;
      end else begin
        case (state_reg)
          ST_RUN: begin
          end
          ST_SUPPLY: begin
            if (ok_s) begin
              cnt_reg <= 13'd0;
              state_reg <= ST_START;
            end
          end
          ST_START: begin
            if (cnt_reg == START_CYC - 13'd1) begin
              cnt_reg <= 13'd0;
              state_reg <= ST_COUNT;
            end else begin
              cnt_reg <= cnt_reg + 13'd1;
            end
          end
          ST_COUNT: begin
            if (cnt_reg == hold_len - 13'd1) begin
              cnt_reg <= 13'd0;
              state_reg <= ST_PIN;
            end else begin
              cnt_reg <= cnt_reg + 13'd1;
            end
          end
          ST_PIN: begin
            if (!(pin_s && ext_reset_pin_enable)) begin
              state_reg <= ST_VEC;
              vector_fetch_addr <= `RSC_VEC_HI;
              vector_fetch_start <= 1'b1;
            end
          end
          ST_VEC: begin
            state_reg <= ST_RUN;
          end
          default: state_reg <= ST_RUN;
        endcase
      end
    end
  end

  assign in_reset = (state_reg != ST_RUN) && (state_reg != ST_VEC);
  wire sys_active = in_reset && sys_kind_reg;

  // Core and peripherals idle, watchdog oscillator left running
  assign core_reset = in_reset;
  assign periph_reset = in_reset;
  assign wd_osc_reset = 1'b0;
  assign regs_reset = sys_active;
  assign port_force_input = in_reset;
  // Internal oscillator selected while held and after any reset
  // osc_enable high keeps the internal oscillator as the system clock
  assign clk_sel_internal = in_reset || osc_enable;
  // Open-drain indicator: drive low during a system reset, but let go
  // in the pin check so that an outside hold can still be seen there
  wire pin_drive = sys_active && (state_reg != ST_PIN);
  assign ext_reset_n_out = 1'b0;
  assign ext_reset_n_oe_n = !pin_drive;

  // Oscillator control: forced on by either reset type
  always @(posedge core_clk) begin
    if (rst)
      osc_enable <= 1'b1;
    else if (in_reset)
      osc_enable <= 1'b1;
    else if (avs_write && avs_address == `RSC_OFS_WDCTL)
      osc_enable <= avs_writedata[0];
  end

  // Debugger request bit; the set holds until reset begins
  always @(posedge core_clk) begin
    if (rst)
      dbg_reg <= 1'b0;
    else if (bus_hit_dbg && avs_writedata[0])
      dbg_reg <= 1'b1;
    else if (in_reset)
      dbg_reg <= 1'b0;
  end

  // Cause flags; latched at the start of a sequence and kept
  always @(posedge core_clk) begin
    if (rst) begin
      // The block's own reset is the power-up, so it reports power-on
      status_reg <= `RSC_STATUS_RST;
      status_reg[`RSC_BIT_POR] <= 1'b1;
      wdctl_reg <= `RSC_WDCTL_RST;
    end else if (sys_req && !in_reset) begin
      status_reg <= `RSC_STATUS_RST;
      status_reg[`RSC_BIT_POR] <= power_req || dbg_req;
      wdctl_reg <= `RSC_WDCTL_RST;
      wdctl_reg[`RSC_BIT_EXT] <= pin_req_reg;
      wdctl_reg[`RSC_BIT_WDT] <= wdt_rst_req;
    end else if (sys_req) begin
      if (power_req || dbg_req)
        status_reg[`RSC_BIT_POR] <= 1'b1;
      if (pin_req_reg)
        wdctl_reg[`RSC_BIT_EXT] <= 1'b1;
      if (wdt_rst_req)
        wdctl_reg[`RSC_BIT_WDT] <= 1'b1;
    end else if (rcv_pulse_reg) begin
      // Recovery touches only watchdog control
      wdctl_reg[`RSC_BIT_RCV] <= 1'b1;
      wdctl_reg[`RSC_BIT_WDT] <= wdt_s;
    end
  end

  // Avalon slave: writes take no wait state; a read takes one, so that
  // the registered data already stands at the accepting edge.
  // Unmapped reads return zero, unmapped writes are dropped.
  reg rd_valid_reg;
  assign avs_waitrequest = avs_read && !rd_valid_reg;
  always @(posedge core_clk) begin
    if (rst)
      rd_valid_reg <= 1'b0;
    else
      rd_valid_reg <= avs_read && !rd_valid_reg;
  end

  // Read data loaded in the wait cycle and held until the next read
  always @(posedge core_clk) begin
    if (rst)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !rd_valid_reg) begin
      case (avs_address)
        `RSC_OFS_STATUS: avs_readdata <= {24'h000000, status_reg};
        `RSC_OFS_DBGCTL: avs_readdata <= {31'h00000000, dbg_reg};
        `RSC_OFS_WDCTL: avs_readdata <= {24'h000000, wdctl_reg[7:1],
                                         osc_enable};
        default: avs_readdata <= 32'h00000000;
      endcase
    end
  end

endmodule
`default_nettype wire

// *** core/rsc_regs.vh ***
// Constants for the reset and stop recovery controller.
// Included by the controller; holds definitions only.
`ifndef RSC_REGS_VH
`define RSC_REGS_VH
// Register byte addresses
`define RSC_OFS_STATUS 12'hff0
`define RSC_OFS_DBGCTL 12'hff4
`define RSC_OFS_WDCTL 12'hff8
// Cause bit positions (POR in status, the rest in watchdog control)
`define RSC_BIT_POR 7
`define RSC_BIT_EXT 6
`define RSC_BIT_WDT 5
`define RSC_BIT_RCV 4
// Reset values
`define RSC_STATUS_RST 8'h00
`define RSC_WDCTL_RST 8'h00
// Timing
`define RSC_CLK_MHZ 200
`define RSC_OSC_START_NS 4000
`define RSC_OSC_START_CYC ((`RSC_OSC_START_NS * `RSC_CLK_MHZ + 999) / 1000)
`define RSC_HOLD_SHORT 66
`define RSC_HOLD_XTAL 5000
`define RSC_PIN_FILT 4
// Vector bytes
`define RSC_VEC_HI 16'h0002
`define RSC_VEC_LO 16'h0003
`endif

// *** dv/rsc_ctrl_assertions.sv ***
// Port checker for the reset controller.
// Assumes a bind onto rsc_ctrl; one clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"
module rsc_ctrl_assertions #(
  parameter HOLD_XTAL = 5000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic por_detect,
  input wire logic supply_low,
  input wire logic ext_reset_n_in,
  input wire logic ext_reset_n_oe_n,
  input wire logic ext_reset_pin_enable,
  input wire logic xtal_enable_option,
  input wire logic core_reset,
  input wire logic periph_reset,
  input wire logic regs_reset,
  input wire logic port_force_input,
  input wire logic clk_sel_internal,
  input wire logic [15:0] vector_fetch_addr,
  input wire logic vector_fetch_start
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Cycles held so far; restarts only lengthen it
  logic [15:0] held_cnt;
  always @(posedge core_clk) begin
    if (rst || !core_reset) held_cnt <= 16'h0000;
    else held_cnt <= held_cnt + 16'h0001;
  end
  hold_len_a: assert property (vector_fetch_start |->
    held_cnt >= `RSC_OSC_START_CYC +
    (xtal_enable_option ? HOLD_XTAL : `RSC_HOLD_SHORT))
    else $error("reset hold too short");
  vec_addr_a: assert property (vector_fetch_start |->
    vector_fetch_addr == 16'h0002 && !core_reset ##1 !core_reset)
    else $error("bad vector fetch");
  dbg_req_a: assert property (avs_write && avs_writedata[0] &&
    avs_address == `RSC_OFS_DBGCTL |-> ##2 core_reset)
    else $error("debugger reset missed");
  fault_hold_a: assert property ((por_detect || supply_low) |->
    ##[1:4] core_reset) else $error("supply fault missed");
  pin_hold_a: assert property ((ext_reset_pin_enable &&
    ext_reset_n_oe_n && !ext_reset_n_in) [*8] |-> core_reset)
    else $error("pin reset missed");
  ports_a: assert property (core_reset |->
    periph_reset && port_force_input) else $error("ports not held");
  regs_sys_a: assert property (regs_reset |-> core_reset)
    else $error("registers reset alone");
  clk_int_a: assert property ($fell(core_reset) |->
    clk_sel_internal) else $error("clock not internal");
  cover property (vector_fetch_start);
  cover property ($rose(regs_reset));
  cover property (core_reset && !regs_reset);
endmodule
bind rsc_ctrl rsc_ctrl_assertions #(.HOLD_XTAL(HOLD_XTAL)) rsc_chk_i (
  .core_clk, .rst, .avs_address, .avs_write, .avs_writedata,
  .por_detect, .supply_low, .ext_reset_n_in, .ext_reset_n_oe_n,
  .ext_reset_pin_enable, .xtal_enable_option, .core_reset,
  .periph_reset, .regs_reset, .port_force_input, .clk_sel_internal,
  .vector_fetch_addr, .vector_fetch_start);
`default_nettype wire

// *** dv/rsc_far_side.sv ***
// Far side: reset pin with pull-up, supply monitor, watchdog.
// Assumes the bench commands it on core_clk edges.
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
  input wire logic core_clk,
  input wire logic pin_press,
  input wire logic fault,
  input wire logic wd_fire,
  input wire logic ext_reset_n_out,
  input wire logic ext_reset_n_oe_n,
  output logic ext_reset_n_in,
  output logic supply_low,
  output logic supply_ok,
  output logic por_detect,
  output logic watchdog_timeout
);
  // Wired-and pin; pull-up wins when nobody sinks it
  assign ext_reset_n_in = !pin_press &&
    (ext_reset_n_oe_n || ext_reset_n_out);
  // Threshold regained some cycles after the fault clears
  logic [2:0] ramp = 3'h0;
  always @(posedge core_clk) begin
    if (fault) ramp <= 3'h0;
    else if (ramp != 3'h7) ramp <= ramp + 3'h1;
  end
  assign supply_low = fault;
  assign supply_ok = ramp == 3'h7;
  assign por_detect = ramp < 3'h3;
  assign watchdog_timeout = wd_fire;
endmodule
`default_nettype wire

// *** dv/reset_and_stop_recovery_ctrl_tb.sv ***
// Bench for the reset controller: bus tasks and sequences.
// Assumes rsc_ctrl, its checker and the far-side model.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_regs.vh"
module reset_and_stop_recovery_ctrl_tb;
  logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0, rd;
  logic pin_press = 0, fault = 0, wd_fire = 0, wd_sel = 1, xtal = 0;
  logic stop = 0;
  logic [7:0] port_in = 8'h00, rcv_en = 8'h00;
  wire [31:0] avs_readdata;
  wire [15:0] vector_fetch_addr;
  wire avs_waitrequest, por_detect, supply_low, supply_ok, core_reset;
  wire watchdog_timeout, ext_reset_n_in, ext_reset_n_out, regs_reset;
  wire ext_reset_n_oe_n, clk_sel_internal, vector_fetch_start;
  int fails = 0, comparisons = 0, n;
  rsc_ctrl #(.HOLD_XTAL(20)) rsc_ctrl_i (.core_clk, .rst, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .por_detect, .supply_low, .supply_ok,
    .watchdog_timeout, .watchdog_reset_select_option(wd_sel),
    .ext_reset_n_in, .ext_reset_n_out, .ext_reset_n_oe_n,
    .ext_reset_pin_enable(1'b1), .xtal_enable_option(xtal),
    .stop_mode(stop), .port_in, .stop_recovery_enable(rcv_en),
    .core_reset, .periph_reset(), .regs_reset, .wd_osc_reset(),
    .port_force_input(), .clk_sel_internal, .vector_fetch_addr,
    .vector_fetch_start, .osc_enable());
  rsc_far_side rsc_far_side_i (.core_clk, .pin_press, .fault, .wd_fire,
    .ext_reset_n_out, .ext_reset_n_oe_n, .ext_reset_n_in, .supply_low,
    .supply_ok, .por_detect, .watchdog_timeout);
  initial forever #2.5 core_clk = ~core_clk;
  task automatic chk(input string nm, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic finish_test;
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // One access; data taken at the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [11:0] a, input int d);
    int k = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin tick(1); k++; end while (avs_waitrequest !== 0 && k < 50);
    if (k >= 50) begin fails++; finish_test(); end
    rd = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
    tick(1);
  endtask
  // Bounded wait for the vector fetch; c counts the cycles taken
  task automatic run_out(output int c);
    c = 0;
    while (vector_fetch_start !== 1 && c < 20000) begin tick(1); c++; end
    if (c >= 20000) begin fails++; finish_test(); end
    chk("fetch addr", vector_fetch_addr, 32'h2);
  endtask
  initial begin
    tick(10);
    rst <= 1'b0;
    run_out(n);
    chk("clk internal", clk_sel_internal, 1);
    bus(0, `RSC_OFS_STATUS, 0);
    chk("por flag", rd[7], 1);
    bus(0, 12'hff1, 0);
    chk("unmapped", rd, 0);
    // Debugger reset with the crystal hold in force
    xtal <= 1;
    bus(1, `RSC_OFS_DBGCTL, 1);
    tick(1);
    chk("dbg reset", core_reset, 1);
    run_out(n);
    chk("xtal hold", n >= `RSC_OSC_START_CYC + 20 && n < 866, 1);
    xtal <= 0;
    bus(0, `RSC_OFS_DBGCTL, 0);
    chk("dbg bit", rd, 0);
    // Too short a pin pulse, then a pin held past the count
    pin_press <= 1;
    tick(2);
    pin_press <= 0;
    tick(20);
    chk("short pulse", core_reset, 0);
    pin_press <= 1;
    tick(1000);
    chk("pin held", core_reset, 1);
    pin_press <= 0;
    run_out(n);
    bus(0, `RSC_OFS_WDCTL, 0);
    chk("ext flag", rd[6], 1);
    // Watchdog time-out, unselected then selected
    for (int s = 0; s < 2; s++) begin
      wd_sel <= s[0];
      wd_fire <= 1;
      tick(1);
      wd_fire <= 0;
      tick(10);
      chk("wd reset", core_reset, s[0]);
    end
    run_out(n);
    bus(0, `RSC_OFS_WDCTL, 0);
    chk("wd flag", rd[5], 1);
    // Brown-out held for a while, then the full count
    fault <= 1;
    tick(100);
    chk("brown-out", core_reset, 1);
    fault <= 0;
    run_out(n);
    chk("hold len", n >= `RSC_OSC_START_CYC + 66, 1);
    // Stop recovery: a disabled pin edge, then an enabled one
    stop <= 1;
    rcv_en <= 8'h01;
    port_in <= 8'h02;
    tick(10);
    chk("masked edge", core_reset, 0);
    port_in <= 8'h03;
    tick(10);
    chk("recovery", {core_reset, regs_reset}, 2'b10);
    run_out(n);
    stop <= 0;
    bus(0, `RSC_OFS_STATUS, 0);
    chk("status kept", rd[7], 1);
    finish_test();
  end
endmodule
`default_nettype wire
